// ===== common/dsr_pkg.sv
package dsr_pkg;

	// register offsets on the serial control bus
	localparam logic [7:0] OFF_TIMING_FREQ    = 8'h1A;
	localparam logic [7:0] OFF_DECODER_STATUS = 8'h1B;
	localparam logic [7:0] OFF_CARRIER_LOCK   = 8'h1C;
	localparam logic [7:0] OFF_ERR_COUNT_HI   = 8'h1D;
	localparam logic [7:0] OFF_ERR_COUNT_LO   = 8'h1E;
	localparam logic [7:0] OFF_SYMRATE_HI     = 8'h1F;
	localparam logic [7:0] OFF_SYMRATE_MID    = 8'h20;
	localparam logic [7:0] OFF_SYMRATE_LO     = 8'h21;
	localparam logic [7:0] OFF_DEROT_HI       = 8'h22;
	localparam logic [7:0] OFF_DEROT_LO       = 8'h23;
	localparam logic [7:0] OFF_NOISE_HI       = 8'h24;
	localparam logic [7:0] OFF_NOISE_LO       = 8'h25;
	localparam logic [7:0] OFF_DEC_ERR_RATE   = 8'h26;
	localparam logic [7:0] OFF_SEARCH_CFG     = 8'h32;

	// decoder status, search config and symbol rate field positions
	localparam int STAT_CARRIER_BIT    = 7;
	localparam int STAT_RATE_FOUND_BIT = 4;
	localparam int STAT_SYNC_BIT       = 3;
	localparam int SEARCH_MANUAL_BIT   = 7;
	localparam int SYMRATE_LO_NIBBLE   = 4;

	// values after reset and for unmapped reads
	localparam logic [7:0]  RST_TIMING_FREQ  = 8'h00;
	localparam logic [7:0]  RST_SYMRATE_HI   = 8'h80;
	localparam logic [7:0]  RST_SYMRATE_MID  = 8'h00;
	localparam logic [3:0]  RST_SYMRATE_LO   = 4'h0;
	localparam logic [19:0] RST_SYMRATE      = 20'h80000;
	localparam logic [15:0] RST_DEROT        = 16'h0000;
	localparam logic [7:0]  RST_SEARCH_CFG   = 8'h19;
	localparam logic [7:0]  RST_READ_DATA    = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

	// active code rate encodings in the status register
	typedef enum logic [2:0] {
		RATE_1_2 = 3'b100,
		RATE_2_3 = 3'b000,
		RATE_3_4 = 3'b001,
		RATE_5_6 = 3'b010,
		RATE_7_8 = 3'b011
	} dsr_rate_t;

endpackage

// ===== core/dsr_pair_snap.sv
`timescale 1ns/10ps

// keeps the two halves of a 16-bit reading coherent across two byte reads
module dsr_pair_snap (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [15:0] live_value,
	input  wire logic        read_high,
	input  wire logic        read_low,
	output logic      [7:0]  high_byte,
	output logic      [7:0]  low_byte
);

	logic [7:0] low_held_reg;
	logic       held_valid_reg;

	// reading the high byte freezes the matching low byte
	always_ff @(posedge mclk) begin
		if (rst) begin
			low_held_reg <= 8'h00;
		end else if (read_high) begin
			low_held_reg <= live_value[7:0];
		end
	end

	// snapshot is consumed by the low read; a new high read wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			held_valid_reg <= 1'b0;
		end else if (read_high) begin
			held_valid_reg <= 1'b1;
		end else if (read_low) begin
			held_valid_reg <= 1'b0;
		end
	end

	assign high_byte = live_value[15:8];
	assign low_byte  = held_valid_reg ? low_held_reg : live_value[7:0];

endmodule

// ===== core/dsr_regs.sv
`timescale 1ns/10ps

// Function
// - status bit 7 shows carrier present
// - status bit 4 shows rate found
// - status bit 3 shows sync acquired
// - status bits 2:0 encode active rate
// - 20-bit symbol rate resets to half clock
// - error count high 1D, low 1E
// - signed derotator high 22, low 23
// - noise indicator high 24, low 25
// - decoder error rate read at 26
// - signed carrier lock value at 1C
// - search config bit 7 selects manual
module dsr_regs (
	input  wire logic              mclk,
	input  wire logic              rst,
	// register port from the serial bus decoder
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// live state from demodulator and decoder
	input  wire logic              carrier_present,
	input  wire logic              rate_found,
	input  wire logic              sync_acquired,
	input  wire logic [2:0]        active_code_rate,
	input  wire logic [7:0]        carrier_lock_value,
	input  wire logic [15:0]       error_count,
	input  wire logic [15:0]       noise_level,
	input  wire logic [7:0]        decoder_error_rate,
	// carrier loop update of the derotator
	input  wire logic              derot_loop_load,
	input  wire logic [15:0]       derot_loop_value,
	// settings to the datapath
	output logic      [7:0]        timing_frequency_value,
	output logic      [19:0]       symbol_rate,
	output logic      [15:0]       derotator_freq,
	output logic      [7:0]        decoder_search_config,
	output logic                   search_manual
);
	import dsr_pkg::*;

	logic [7:0]  status_reg;
	logic [7:0]  carrier_lock_reg;
	logic [7:0]  dec_err_rate_reg;
	logic [15:0] err_count_reg;
	logic [15:0] noise_reg;
	logic [7:0]  timing_reg;
	logic [7:0]  symrate_hi_reg;
	logic [7:0]  symrate_mid_reg;
	logic [3:0]  symrate_lo_reg;
	logic [15:0] derot_reg;
	logic [7:0]  search_cfg_reg;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic [2:0]  rate_code_next;
	logic        wr_timing;
	logic        wr_sym_hi;
	logic        wr_sym_mid;
	logic        wr_sym_lo;
	logic        wr_derot_hi;
	logic        wr_derot_lo;
	logic        wr_search;
	logic        rd_err_hi;
	logic        rd_err_lo;
	logic        rd_noise_hi;
	logic        rd_noise_lo;
	logic [7:0]  err_hi_byte;
	logic [7:0]  err_lo_byte;
	logic [7:0]  noise_hi_byte;
	logic [7:0]  noise_lo_byte;

	// write strobes exist only for writable offsets
	assign wr_timing   = reg_wr && (reg_addr == OFF_TIMING_FREQ);
	assign wr_sym_hi   = reg_wr && (reg_addr == OFF_SYMRATE_HI);
	assign wr_sym_mid  = reg_wr && (reg_addr == OFF_SYMRATE_MID);
	assign wr_sym_lo   = reg_wr && (reg_addr == OFF_SYMRATE_LO);
	assign wr_derot_hi = reg_wr && (reg_addr == OFF_DEROT_HI);
	assign wr_derot_lo = reg_wr && (reg_addr == OFF_DEROT_LO);
	assign wr_search   = reg_wr && (reg_addr == OFF_SEARCH_CFG);

	// byte read strobes for the paired readings
	assign rd_err_hi   = reg_rd && (reg_addr == OFF_ERR_COUNT_HI);
	assign rd_err_lo   = reg_rd && (reg_addr == OFF_ERR_COUNT_LO);
	assign rd_noise_hi = reg_rd && (reg_addr == OFF_NOISE_HI);
	assign rd_noise_lo = reg_rd && (reg_addr == OFF_NOISE_LO);

	// reserved rate codes keep the last legal code on display
	always_comb begin
		case (active_code_rate)
			RATE_1_2: rate_code_next = active_code_rate;
			RATE_2_3: rate_code_next = active_code_rate;
			RATE_3_4: rate_code_next = active_code_rate;
			RATE_5_6: rate_code_next = active_code_rate;
			RATE_7_8: rate_code_next = active_code_rate;
			default:  rate_code_next = status_reg[2:0];
		endcase
	end

	// decoder status sampled every cycle; bits 6:5 read zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_reg <= {5'h00, RATE_1_2};
		end else begin
			status_reg[STAT_CARRIER_BIT]    <= carrier_present;
			status_reg[6:5]                 <= 2'h0;
			status_reg[STAT_RATE_FOUND_BIT] <= rate_found;
			status_reg[STAT_SYNC_BIT]       <= sync_acquired;
			status_reg[2:0]                 <= rate_code_next;
		end
	end

	// measurement readings are written only by the datapath
	always_ff @(posedge mclk) begin
		if (rst) begin
			carrier_lock_reg <= 8'h00;
			dec_err_rate_reg <= 8'h00;
			err_count_reg    <= 16'h0000;
			noise_reg        <= 16'h0000;
		end else begin
			carrier_lock_reg <= carrier_lock_value;
			dec_err_rate_reg <= decoder_error_rate;
			err_count_reg    <= error_count;
			noise_reg        <= noise_level;
		end
	end

	// error count halves stay coherent between the two byte reads
	dsr_pair_snap u_err_pair (
		.mclk       (mclk),
		.rst        (rst),
		.live_value (err_count_reg),
		.read_high  (rd_err_hi),
		.read_low   (rd_err_lo),
		.high_byte  (err_hi_byte),
		.low_byte   (err_lo_byte)
	);

	// same treatment for the noise indicator
	dsr_pair_snap u_noise_pair (
		.mclk       (mclk),
		.rst        (rst),
		.live_value (noise_reg),
		.read_high  (rd_noise_hi),
		.read_low   (rd_noise_lo),
		.high_byte  (noise_hi_byte),
		.low_byte   (noise_lo_byte)
	);

	// timing frequency setting, signed
	always_ff @(posedge mclk) begin
		if (rst) begin
			timing_reg <= RST_TIMING_FREQ;
		end else if (wr_timing) begin
			timing_reg <= reg_wdata;
		end
	end

	// symbol rate: 20 bits over three registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			symrate_hi_reg  <= RST_SYMRATE_HI;
			symrate_mid_reg <= RST_SYMRATE_MID;
			symrate_lo_reg  <= RST_SYMRATE_LO;
		end else begin
			if (wr_sym_hi) begin
				symrate_hi_reg <= reg_wdata;
			end
			if (wr_sym_mid) begin
				symrate_mid_reg <= reg_wdata;
			end
			// only the upper nibble is stored; the low nibble is discarded
			if (wr_sym_lo) begin
				symrate_lo_reg <= reg_wdata[7:SYMRATE_LO_NIBBLE];
			end
		end
	end

	// derotator: host byte writes win over a loop update in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			derot_reg <= RST_DEROT;
		end else if (wr_derot_hi || wr_derot_lo) begin
			if (wr_derot_hi) begin
				derot_reg[15:8] <= reg_wdata;
			end
			if (wr_derot_lo) begin
				derot_reg[7:0] <= reg_wdata;
			end
		end else if (derot_loop_load) begin
			derot_reg <= derot_loop_value;
		end
	end

	// search configuration; bit 7 picks manual search
	always_ff @(posedge mclk) begin
		if (rst) begin
			search_cfg_reg <= RST_SEARCH_CFG;
		end else if (wr_search) begin
			search_cfg_reg <= reg_wdata;
		end
	end

	// read multiplexer; read-only offsets have no write path at all
	always_comb begin
		case (reg_addr)
			OFF_TIMING_FREQ:    rdata_next = timing_reg;
			OFF_DECODER_STATUS: rdata_next = status_reg;
			OFF_CARRIER_LOCK:   rdata_next = carrier_lock_reg;
			OFF_ERR_COUNT_HI:   rdata_next = err_hi_byte;
			OFF_ERR_COUNT_LO:   rdata_next = err_lo_byte;
			OFF_SYMRATE_HI:     rdata_next = symrate_hi_reg;
			OFF_SYMRATE_MID:    rdata_next = symrate_mid_reg;
			OFF_SYMRATE_LO:     rdata_next = {symrate_lo_reg, 4'h0};
			OFF_DEROT_HI:       rdata_next = derot_reg[15:8];
			OFF_DEROT_LO:       rdata_next = derot_reg[7:0];
			OFF_NOISE_HI:       rdata_next = noise_hi_byte;
			OFF_NOISE_LO:       rdata_next = noise_lo_byte;
			OFF_DEC_ERR_RATE:   rdata_next = dec_err_rate_reg;
			OFF_SEARCH_CFG:     rdata_next = search_cfg_reg;
			default:            rdata_next = UNMAPPED_READ;
		endcase
	end

	// read data is registered and held until the next read
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_reg <= RST_READ_DATA;
		end else if (reg_rd) begin
			rdata_reg <= rdata_next;
		end
	end

	// outputs to the bus and the datapath
	assign reg_rdata              = rdata_reg;
	assign timing_frequency_value = timing_reg;
	assign symbol_rate            = {symrate_hi_reg, symrate_mid_reg, symrate_lo_reg};
	assign derotator_freq         = derot_reg;
	assign decoder_search_config  = search_cfg_reg;
	assign search_manual          = search_cfg_reg[SEARCH_MANUAL_BIT];

	// checks on the register behaviour
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_status_carrier: assert property (
		reg_rd && reg_addr == OFF_DECODER_STATUS
		|=> reg_rdata[STAT_CARRIER_BIT] == $past(carrier_present, 2))
		else $error("carrier flag read back wrong");

	a_status_rate_found: assert property (
		reg_rd && reg_addr == OFF_DECODER_STATUS
		|=> reg_rdata[STAT_RATE_FOUND_BIT] == $past(rate_found, 2))
		else $error("rate found flag read back wrong");

	a_status_sync: assert property (
		reg_rd && reg_addr == OFF_DECODER_STATUS
		|=> reg_rdata[STAT_SYNC_BIT] == $past(sync_acquired, 2))
		else $error("sync flag read back wrong");

	a_status_code_rate: assert property (
		reg_rd && reg_addr == OFF_DECODER_STATUS && $past(active_code_rate) == 3'b011
		|=> reg_rdata[2:0] == 3'b011 && reg_rdata[6:5] == 2'b00)
		else $error("code rate field wrong");

	a_symrate_reset: assert property (
		@(posedge mclk) $past(rst) && !wr_sym_hi |-> symbol_rate == 20'h80000)
		else $error("symbol rate reset value wrong");

	a_symrate_nibble: assert property (
		reg_rd && reg_addr == OFF_SYMRATE_LO |=> reg_rdata[3:0] == 4'h0)
		else $error("symbol rate low nibble not zero");

	a_err_count_pair: assert property (
		rd_err_hi ##1 (rd_err_lo && !rd_err_hi)
		|=> reg_rdata == $past(err_count_reg[7:0], 2))
		else $error("error count low byte not coherent");

	a_derot_write: assert property (
		wr_derot_hi |=> derotator_freq[15:8] == $past(reg_wdata))
		else $error("derotator high byte not written");

	a_noise_high: assert property (
		rd_noise_hi |=> reg_rdata == $past(noise_level[15:8], 2))
		else $error("noise high byte wrong");

	a_dec_error_rate: assert property (
		reg_rd && reg_addr == OFF_DEC_ERR_RATE |=> reg_rdata == $past(decoder_error_rate, 2))
		else $error("decoder error rate wrong");

	a_carrier_lock: assert property (
		reg_rd && reg_addr == OFF_CARRIER_LOCK |=> reg_rdata == $past(carrier_lock_value, 2))
		else $error("carrier lock value wrong");

	a_search_mode: assert property (
		wr_search |=> search_manual == $past(reg_wdata[7]) ##1 search_manual == $past(reg_wdata[7], 2) || $past(wr_search))
		else $error("search mode bit not taken");

	a_ro_ignored: assert property (
		reg_wr && !derot_loop_load
		&& (reg_addr == OFF_DECODER_STATUS || reg_addr == OFF_DEC_ERR_RATE
		|| reg_addr == OFF_CARRIER_LOCK || reg_addr == OFF_NOISE_HI)
		|=> $stable(symbol_rate) && $stable(timing_frequency_value)
		&& $stable(decoder_search_config) && $stable(derotator_freq))
		else $error("read-only write disturbed state");

	a_err_pair_spaced: assert property (
		rd_err_hi ##1 (!rd_err_hi && !rd_err_lo) [*2] ##1 rd_err_lo
		|=> reg_rdata == $past(err_count_reg[7:0], 4))
		else $error("spaced error count low byte not coherent");

	a_noise_pair_low: assert property (
		rd_noise_hi ##1 (!rd_noise_hi && !rd_noise_lo) ##1 rd_noise_lo
		|=> reg_rdata == $past(noise_reg[7:0], 3))
		else $error("noise low byte not coherent");

	a_derot_loop: assert property (
		derot_loop_load && !wr_derot_hi && !wr_derot_lo
		|=> derotator_freq == $past(derot_loop_value))
		else $error("derotator loop load not taken");

	a_derot_host_wins: assert property (
		wr_derot_lo && derot_loop_load
		|=> derotator_freq[7:0] == $past(reg_wdata))
		else $error("loop load overrode host write");

	a_symrate_write: assert property (
		wr_sym_lo |=> symbol_rate[3:0] == $past(reg_wdata[7:SYMRATE_LO_NIBBLE]))
		else $error("symbol rate low bits not written");

	a_code_rate_any: assert property (
		reg_rd && reg_addr == OFF_DECODER_STATUS
		&& ($past(active_code_rate) == RATE_1_2 || !$past(active_code_rate[2]))
		|=> reg_rdata[2:0] == $past(active_code_rate, 2))
		else $error("active code rate read back wrong");

	a_search_reset: assert property (
		$past(rst) |-> decoder_search_config == RST_SEARCH_CFG && derotator_freq == RST_DEROT)
		else $error("search config or derotator reset value wrong");

	c_status_read: cover property (reg_rd && reg_addr == OFF_DECODER_STATUS && carrier_present);
	c_manual_read: cover property (search_manual && reg_rd && reg_addr == OFF_DECODER_STATUS);
	c_err_pair_read: cover property (rd_err_hi ##[1:4] rd_err_lo);
	c_symrate_write: cover property (wr_sym_hi ##[1:8] wr_sym_lo);
	c_derot_clash: cover property (wr_derot_lo && derot_loop_load);

endmodule

// ===== tb/dsr_host.sv
`timescale 1ns/10ps

// host on the register port: one-cycle strobes, idle bus parked on inverted values
module dsr_host (
	input  wire logic       mclk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	import dsr_pkg::*;

	// bus idle from time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// single write; symbol rate low nibble always goes out as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] w;
		w = (a == OFF_SYMRATE_LO) ? {v[7:4], 4'h0} : v;
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~w;
	endtask

	// single read; data lands at the edge that takes the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rdata;
	endtask

	// search mode select, other fields kept at their reset setting
	task automatic set_manual(input logic m);
		wr(OFF_SEARCH_CFG, {m, RST_SEARCH_CFG[6:0]});
	endtask

	// status read; rate-found carries no meaning in manual search
	task automatic rd_status(input logic manual, output logic [7:0] v);
		rd(OFF_DECODER_STATUS, v);
		if (manual) v[STAT_RATE_FOUND_BIT] = 1'b0;
	endtask
endmodule

// ===== tb/demod_status_tuning_registers_test.sv
`timescale 1ns/10ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module demod_status_tuning_registers_test;
	import dsr_pkg::*;
	logic        mclk, rst, reg_wr, reg_rd, derot_loop_load, search_manual;
	logic        carrier_present, rate_found, sync_acquired;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, carrier_lock_value, decoder_error_rate;
	logic [7:0]  timing_frequency_value, decoder_search_config, d;
	logic [2:0]  active_code_rate;
	logic [15:0] error_count, noise_level, derot_loop_value, derotator_freq;
	logic [19:0] symbol_rate;
	int          miscompares, cmp_count, cycles;
	logic [7:0]  codes_ro [7] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h24, 8'h25, 8'h26};

	dsr_host HOST (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));

	dsr_regs DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.carrier_present(carrier_present), .rate_found(rate_found),
		.sync_acquired(sync_acquired), .active_code_rate(active_code_rate),
		.carrier_lock_value(carrier_lock_value), .error_count(error_count),
		.noise_level(noise_level), .decoder_error_rate(decoder_error_rate),
		.derot_loop_load(derot_loop_load), .derot_loop_value(derot_loop_value),
		.timing_frequency_value(timing_frequency_value), .symbol_rate(symbol_rate),
		.derotator_freq(derotator_freq), .decoder_search_config(decoder_search_config),
		.search_manual(search_manual));

	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// cut a hang short
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	// counts and verdict
	task automatic print_verdict();
		$display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// values straight after reset
	task automatic t_reset();
		`CHK(symbol_rate, RST_SYMRATE)
		`CHK(search_manual, 1'b0)
		`CHK(decoder_search_config, RST_SEARCH_CFG)
		`CHK(derotator_freq, RST_DEROT)
		HOST.rd(OFF_SYMRATE_HI, d);
		`CHK(d, 8'h80)
		HOST.rd(OFF_SYMRATE_LO, d);
		`CHK(d, 8'h00)
	endtask

	// every rate code with changing flags, then a reserved code
	task automatic t_status();
		dsr_rate_t codes [5] = '{RATE_1_2, RATE_2_3, RATE_3_4, RATE_5_6, RATE_7_8};
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			active_code_rate <= codes[i];
			carrier_present <= i[0];
			rate_found <= i[1];
			sync_acquired <= ~i[0];
			HOST.rd(OFF_DECODER_STATUS, d);
			`CHK(d, {i[0], 2'b00, i[1], ~i[0], codes[i]})
		end
		@(posedge mclk);
		active_code_rate <= 3'b111;
		HOST.rd(OFF_DECODER_STATUS, d);
		`CHK(d[2:0], 3'b011)
	endtask

	// measurement readings, byte pairing, writes to read-only places, unmapped read
	task automatic t_measure();
		@(posedge mclk);
		carrier_lock_value <= 8'h80;
		error_count <= 16'hBEEF;
		noise_level <= 16'h1234;
		decoder_error_rate <= 8'hFF;
		HOST.rd(OFF_CARRIER_LOCK, d);
		`CHK(d, 8'h80)
		HOST.rd(OFF_ERR_COUNT_HI, d);
		`CHK(d, 8'hBE)
		@(posedge mclk);
		error_count <= 16'h0001;
		HOST.rd(OFF_ERR_COUNT_LO, d);
		`CHK(d, 8'hEF)
		HOST.rd(OFF_NOISE_HI, d);
		`CHK(d, 8'h12)
		HOST.rd(OFF_NOISE_LO, d);
		`CHK(d, 8'h34)
		HOST.wr(OFF_TIMING_FREQ, 8'hC3);
		foreach (codes_ro[i]) HOST.wr(codes_ro[i], 8'h5A);
		`CHK(timing_frequency_value, 8'hC3)
		`CHK(symbol_rate, RST_SYMRATE)
		`CHK(derotator_freq, RST_DEROT)
		`CHK(decoder_search_config, RST_SEARCH_CFG)
		HOST.rd(OFF_ERR_COUNT_LO, d);
		`CHK(d, 8'h01)
		HOST.rd(OFF_CARRIER_LOCK, d);
		`CHK(d, 8'h80)
		HOST.rd(OFF_DEC_ERR_RATE, d);
		`CHK(d, 8'hFF)
		HOST.rd(8'h40, d);
		`CHK(d, UNMAPPED_READ)
		HOST.rd(OFF_TIMING_FREQ, d);
		`CHK(d, 8'hC3)
	endtask

	// symbol rate and derotator settings, then a carrier loop load
	task automatic t_settings();
		HOST.wr(OFF_SYMRATE_HI, 8'h12);
		HOST.wr(OFF_SYMRATE_MID, 8'h34);
		HOST.wr(OFF_SYMRATE_LO, 8'h5F);
		#1;
		`CHK(symbol_rate, 20'h12345)
		HOST.rd(OFF_SYMRATE_LO, d);
		`CHK(d, 8'h50)
		HOST.wr(OFF_DEROT_HI, 8'hFE);
		HOST.wr(OFF_DEROT_LO, 8'h01);
		#1;
		`CHK(derotator_freq, 16'hFE01)
		HOST.rd(OFF_DEROT_LO, d);
		`CHK(d, 8'h01)
		@(posedge mclk);
		derot_loop_load <= 1'b1;
		derot_loop_value <= 16'h8000;
		@(posedge mclk);
		derot_loop_load <= 1'b0;
		HOST.rd(OFF_DEROT_HI, d);
		`CHK(d, 8'h80)
	endtask

	// manual search mode hides nothing else in the status
	task automatic t_search();
		HOST.set_manual(1'b1);
		#1;
		`CHK(decoder_search_config, 8'h99)
		`CHK(search_manual, 1'b1)
		@(posedge mclk);
		rate_found <= 1'b1;
		carrier_present <= 1'b1;
		sync_acquired <= 1'b1;
		active_code_rate <= RATE_3_4;
		HOST.rd_status(search_manual, d);
		`CHK(d, 8'h89)
		HOST.set_manual(1'b0);
		#1;
		`CHK(search_manual, 1'b0)
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		{carrier_present, rate_found, sync_acquired, derot_loop_load} = 4'h0;
		active_code_rate = 3'b100;
		{carrier_lock_value, decoder_error_rate} = 16'h0000;
		{error_count, noise_level, derot_loop_value} = 48'h0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_status();
		t_measure();
		t_settings();
		t_search();
		print_verdict();
	end
endmodule
